// ### rtl/sdt_pkg.sv
// constants for the sdram timing and control register block
package sdt_pkg;
	// ==========================================================
	// register byte offsets
	localparam logic [11:0] TIMING_OFFSET  = 12'h000;
	localparam logic [11:0] CONTROL_OFFSET = 12'h004;
	localparam logic [11:0] STATUS_OFFSET  = 12'h008;
	// ==========================================================
	// timing register fields
	localparam int TWR_LSB = 3;
	localparam int TRC_LSB = 0;
	localparam logic [1:0] TWR_RESET      = 2'h0;
	localparam logic [1:0] TRC_RESET      = 2'h0;
	localparam logic [1:0] TWR_PROHIBITED = 2'h3;
	// ==========================================================
	// control register fields and reserved bit masks
	localparam int ROW_LSB  = 19;
	localparam int COL_LSB  = 16;
	localparam int SLOW_BIT = 12;
	localparam int REN_BIT  = 11;
	localparam int KIND_BIT = 10;
	localparam logic [1:0] ROW_RESET       = 2'h0;
	localparam logic [1:0] COL_RESET       = 2'h0;
	localparam logic [1:0] ROW_PROHIBITED  = 2'h3;
	localparam logic [1:0] COL_PROHIBITED  = 2'h3;
	localparam logic       SLOW_RESET      = 1'h0;
	localparam logic       REN_RESET       = 1'h0;
	localparam logic       KIND_RESET      = 1'h0;
	localparam logic [31:0] TIMING_RSVD_MASK  = 32'hFFFF_FFE4;
	localparam logic [31:0] CONTROL_RSVD_MASK = 32'hFFE4_E3FF;
	// ==========================================================
	// status register fields
	localparam int STAT_PRE_BIT  = 0;
	localparam int STAT_ACT_BIT  = 1;
	localparam int STAT_SELF_BIT = 2;
	// ==========================================================
	// address widths and cycle counts
	localparam logic [3:0] ROW_BASE = 4'hB;
	localparam logic [3:0] COL_BASE = 4'h8;
	localparam logic [3:0] TWR_CYC_0 = 4'h0;
	localparam logic [3:0] TWR_CYC_1 = 4'h1;
	localparam logic [3:0] TWR_CYC_2 = 4'h2;
	localparam logic [3:0] TRC_CYC_0 = 4'h3;
	localparam logic [3:0] TRC_CYC_1 = 4'h4;
	localparam logic [3:0] TRC_CYC_2 = 4'h6;
	localparam logic [3:0] TRC_CYC_3 = 4'h9;
endpackage

// ### rtl/sdt_code_field.sv
// two-bit style code field that refuses a prohibited code
`timescale 1ns/1ps
module sdt_code_field #(
	parameter int         W          = 2,
	parameter bit         HAS_PROHIB = 1'b1,
	parameter logic [W-1:0] PROHIB   = '1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         wr_i,
	input  wire logic [W-1:0] data_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] next_q;

	if (W < 1) begin : g_chk
		$error("sdt_code_field: W must be at least 1");
	end

	always_comb begin
		next_q = q_o;
		if (wr_i && !(HAS_PROHIB && data_i == PROHIB)) begin
			next_q = data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_o <= RESET_VAL;
		end else begin
			q_o <= next_q;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_prohib_kept;
		wr_i && HAS_PROHIB && data_i == PROHIB |=> $stable(q_o);
	endproperty
	a_prohib_kept: assert property (p_prohib_kept) else $error("prohibited code stored");
endmodule

// ### rtl/sdt_gap_timer.sv
// spacing timer: ready stays low for the loaded number of cycles
`timescale 1ns/1ps
module sdt_gap_timer #(
	parameter int CNT_W = 4
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             start_i,
	input  wire logic [CNT_W-1:0] len_i,
	output logic                  ready_o
);
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic             next_ready;

	if (CNT_W < 2) begin : g_chk
		$error("sdt_gap_timer: CNT_W must be at least 2");
	end

	always_comb begin
		next_cnt = cnt;
		if (start_i) begin
			next_cnt = len_i;
		end else if (cnt != '0) begin
			next_cnt = cnt - 1'b1;
		end
		next_ready = (next_cnt == '0);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt     <= '0;
			ready_o <= 1'b1;
		end else begin
			cnt     <= next_cnt;
			ready_o <= next_ready;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_start_blocks;
		start_i && len_i != '0 |=> !ready_o;
	endproperty
	a_start_blocks: assert property (p_start_blocks) else $error("ready too early");

	property p_release;
		!start_i && cnt == 1 |=> ready_o;
	endproperty
	a_release: assert property (p_release) else $error("ready not released");
endmodule

// ### rtl/sdt_timing_config.sv
// sdram timing and control registers with command spacing timers
//
// Function
// - write command to precharge waits 0, 1 or 2 cycles; code 3 refused
// - refresh or self-refresh exit to activate waits 3, 4, 6 or 9 cycles
// - reserved register bits read zero; software writes zero
// - area 2 row width 11, 12 or 13 bits; code 3 refused
// - area 2 column width 8, 9 or 10 bits; code 3 refused
// - no refresh at all while refresh enable is zero
// - refresh kind one starts self-refresh, zero paces auto-refresh
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
module sdt_timing_config #(
	parameter int ADDR_W = 12
) (
	input  wire logic              SYS_CLK_I,
	input  wire logic              SYS_RST_I,
	input  wire logic              PSEL_I,
	input  wire logic              PENABLE_I,
	input  wire logic              PWRITE_I,
	input  wire logic [ADDR_W-1:0] PADDR_I,
	input  wire logic [31:0]       PWDATA_I,
	output logic      [31:0]       PRDATA_O,
	output logic                   PREADY_O,
	output logic                   PSLVERR_O,
	input  wire logic              WRITE_CMD_I,
	input  wire logic              REFRESH_CMD_I,
	input  wire logic              REFRESH_TICK_I,
	output logic                   PRECHARGE_OK_O,
	output logic                   ACTIVATE_OK_O,
	output logic                   REFRESH_ENABLE_O,
	output logic                   SELF_REFRESH_O,
	output logic                   AUTO_REFRESH_REQ_O,
	output logic                   LOW_FREQ_MODE_O,
	output logic      [3:0]        ROW_BITS_O,
	output logic      [3:0]        COL_BITS_O
);
	// ==========================================================
	// elaboration check
	if (ADDR_W < 12) begin : g_chk
		$error("sdt_timing_config: ADDR_W must be at least 12");
	end

	// ==========================================================
	// bus decode
	logic [11:0] addr;
	logic        setup;
	logic        access;
	logic        hit_timing;
	logic        hit_control;
	logic        hit_status;
	logic        hit_any;
	logic        wr_timing;
	logic        wr_control;

	assign addr        = PADDR_I[11:0];
	assign setup       = PSEL_I && !PENABLE_I;
	assign access      = PSEL_I && PENABLE_I && PREADY_O;
	assign hit_timing  = addr == sdt_pkg::TIMING_OFFSET;
	assign hit_control = addr == sdt_pkg::CONTROL_OFFSET;
	assign hit_status  = addr == sdt_pkg::STATUS_OFFSET;
	assign hit_any     = (hit_timing || hit_control || hit_status)
		&& (PADDR_I >> 12) == '0;
	assign wr_timing   = access && PWRITE_I && hit_any && hit_timing;
	assign wr_control  = access && PWRITE_I && hit_any && hit_control;

	// ==========================================================
	// coded fields
	logic [1:0] twr_code;
	logic [1:0] row_code;
	logic [1:0] col_code;

	sdt_code_field #(
		.W          (2),
		.HAS_PROHIB (1'b1),
		.PROHIB     (sdt_pkg::TWR_PROHIBITED),
		.RESET_VAL  (sdt_pkg::TWR_RESET)
	) u_twr (
		.clk_i  (SYS_CLK_I),
		.rst_i  (SYS_RST_I),
		.wr_i   (wr_timing),
		.data_i (PWDATA_I[sdt_pkg::TWR_LSB +: 2]),
		.q_o    (twr_code)
	);

	sdt_code_field #(
		.W          (2),
		.HAS_PROHIB (1'b1),
		.PROHIB     (sdt_pkg::ROW_PROHIBITED),
		.RESET_VAL  (sdt_pkg::ROW_RESET)
	) u_row (
		.clk_i  (SYS_CLK_I),
		.rst_i  (SYS_RST_I),
		.wr_i   (wr_control),
		.data_i (PWDATA_I[sdt_pkg::ROW_LSB +: 2]),
		.q_o    (row_code)
	);

	sdt_code_field #(
		.W          (2),
		.HAS_PROHIB (1'b1),
		.PROHIB     (sdt_pkg::COL_PROHIBITED),
		.RESET_VAL  (sdt_pkg::COL_RESET)
	) u_col (
		.clk_i  (SYS_CLK_I),
		.rst_i  (SYS_RST_I),
		.wr_i   (wr_control),
		.data_i (PWDATA_I[sdt_pkg::COL_LSB +: 2]),
		.q_o    (col_code)
	);

	// ==========================================================
	// plain register bits
	logic [1:0] trc_code;
	logic       low_freq;
	logic       refresh_enable;
	logic       refresh_kind_select;
	logic [1:0] next_trc_code;
	logic       next_low_freq;
	logic       next_refresh_enable;
	logic       next_refresh_kind_select;

	always_comb begin
		next_trc_code            = trc_code;
		next_low_freq            = low_freq;
		next_refresh_enable      = refresh_enable;
		next_refresh_kind_select = refresh_kind_select;
		if (wr_timing) begin
			next_trc_code = PWDATA_I[sdt_pkg::TRC_LSB +: 2];
		end
		if (wr_control) begin
			next_low_freq            = PWDATA_I[sdt_pkg::SLOW_BIT];
			next_refresh_enable      = PWDATA_I[sdt_pkg::REN_BIT];
			next_refresh_kind_select = PWDATA_I[sdt_pkg::KIND_BIT];
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			trc_code            <= sdt_pkg::TRC_RESET;
			low_freq            <= sdt_pkg::SLOW_RESET;
			refresh_enable      <= sdt_pkg::REN_RESET;
			refresh_kind_select <= sdt_pkg::KIND_RESET;
		end else begin
			trc_code            <= next_trc_code;
			low_freq            <= next_low_freq;
			refresh_enable      <= next_refresh_enable;
			refresh_kind_select <= next_refresh_kind_select;
		end
	end

	// ==========================================================
	// spacing timers
	logic [3:0] twr_len;
	logic [3:0] trc_len;
	logic       self_exit;
	logic       trc_start;

	always_comb begin
		unique case (twr_code)
			2'h0:    twr_len = sdt_pkg::TWR_CYC_0;
			2'h1:    twr_len = sdt_pkg::TWR_CYC_1;
			2'h2:    twr_len = sdt_pkg::TWR_CYC_2;
			default: twr_len = sdt_pkg::TWR_CYC_2;
		endcase
		unique case (trc_code)
			2'h0: trc_len = sdt_pkg::TRC_CYC_0;
			2'h1: trc_len = sdt_pkg::TRC_CYC_1;
			2'h2: trc_len = sdt_pkg::TRC_CYC_2;
			2'h3: trc_len = sdt_pkg::TRC_CYC_3;
		endcase
	end

	// leaving self-refresh restarts the activate spacing
	assign self_exit = SELF_REFRESH_O && !(refresh_enable && refresh_kind_select);
	assign trc_start = REFRESH_CMD_I || self_exit;

	sdt_gap_timer #(
		.CNT_W (4)
	) u_twr_gap (
		.clk_i   (SYS_CLK_I),
		.rst_i   (SYS_RST_I),
		.start_i (WRITE_CMD_I),
		.len_i   (twr_len),
		.ready_o (PRECHARGE_OK_O)
	);

	sdt_gap_timer #(
		.CNT_W (4)
	) u_trc_gap (
		.clk_i   (SYS_CLK_I),
		.rst_i   (SYS_RST_I),
		.start_i (trc_start),
		.len_i   (trc_len),
		.ready_o (ACTIVATE_OK_O)
	);

	// ==========================================================
	// refresh control and width outputs
	logic       next_self;
	logic       next_auto;
	logic [3:0] next_row_bits;
	logic [3:0] next_col_bits;

	always_comb begin
		next_self     = refresh_enable && refresh_kind_select;
		next_auto     = refresh_enable && !refresh_kind_select && REFRESH_TICK_I;
		next_row_bits = sdt_pkg::ROW_BASE + {2'h0, row_code};
		next_col_bits = sdt_pkg::COL_BASE + {2'h0, col_code};
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			SELF_REFRESH_O     <= 1'b0;
			AUTO_REFRESH_REQ_O <= 1'b0;
			REFRESH_ENABLE_O   <= 1'b0;
			LOW_FREQ_MODE_O    <= 1'b0;
			ROW_BITS_O         <= sdt_pkg::ROW_BASE;
			COL_BITS_O         <= sdt_pkg::COL_BASE;
		end else begin
			SELF_REFRESH_O     <= next_self;
			AUTO_REFRESH_REQ_O <= next_auto;
			REFRESH_ENABLE_O   <= refresh_enable;
			LOW_FREQ_MODE_O    <= low_freq;
			ROW_BITS_O         <= next_row_bits;
			COL_BITS_O         <= next_col_bits;
		end
	end

	// ==========================================================
	// apb answer
	logic [31:0] rd_word;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;

	always_comb begin
		rd_word = 32'h0000_0000;
		if (hit_timing) begin
			rd_word[sdt_pkg::TWR_LSB +: 2] = twr_code;
			rd_word[sdt_pkg::TRC_LSB +: 2] = trc_code;
		end else if (hit_control) begin
			rd_word[sdt_pkg::ROW_LSB +: 2] = row_code;
			rd_word[sdt_pkg::COL_LSB +: 2] = col_code;
			rd_word[sdt_pkg::SLOW_BIT]     = low_freq;
			rd_word[sdt_pkg::REN_BIT]      = refresh_enable;
			rd_word[sdt_pkg::KIND_BIT]     = refresh_kind_select;
		end else if (hit_status) begin
			rd_word[sdt_pkg::STAT_PRE_BIT]  = PRECHARGE_OK_O;
			rd_word[sdt_pkg::STAT_ACT_BIT]  = ACTIVATE_OK_O;
			rd_word[sdt_pkg::STAT_SELF_BIT] = SELF_REFRESH_O;
		end
		next_pready  = setup;
		next_pslverr = setup && !hit_any;
		next_prdata  = PRDATA_O;
		if (setup) begin
			next_prdata = (hit_any && !PWRITE_I) ? rd_word : 32'h0000_0000;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			PRDATA_O  <= 32'h0000_0000;
			PREADY_O  <= 1'b0;
			PSLVERR_O <= 1'b0;
		end else begin
			PRDATA_O  <= next_prdata;
			PREADY_O  <= next_pready;
			PSLVERR_O <= next_pslverr;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (SYS_RST_I);

	property p_twr_two;
		(WRITE_CMD_I && twr_code == 2'h2) ##1 (!WRITE_CMD_I)[*2]
			|-> !PRECHARGE_OK_O ##1 PRECHARGE_OK_O;
	endproperty
	a_twr_two: assert property (p_twr_two) else $error("write gap not two");

	property p_twr_zero;
		WRITE_CMD_I && twr_code == 2'h0 |=> PRECHARGE_OK_O;
	endproperty
	a_twr_zero: assert property (p_twr_zero) else $error("write gap not zero");

	property p_trc_three;
		(trc_start && trc_code == 2'h0) ##1 (!trc_start)[*3]
			|-> !ACTIVATE_OK_O ##1 ACTIVATE_OK_O;
	endproperty
	a_trc_three: assert property (p_trc_three) else $error("refresh gap not three");

	property p_rsvd_zero;
		access && !PWRITE_I && hit_control
			|-> (PRDATA_O & sdt_pkg::CONTROL_RSVD_MASK) == 32'h0000_0000;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read one");

	property p_no_refresh;
		!refresh_enable |=> !SELF_REFRESH_O && !AUTO_REFRESH_REQ_O;
	endproperty
	a_no_refresh: assert property (p_no_refresh) else $error("refresh while off");

	property p_self_start;
		refresh_enable && refresh_kind_select |=> SELF_REFRESH_O;
	endproperty
	a_self_start: assert property (p_self_start) else $error("self-refresh late");

	property p_auto_tick;
		refresh_enable && !refresh_kind_select && REFRESH_TICK_I |=> AUTO_REFRESH_REQ_O;
	endproperty
	a_auto_tick: assert property (p_auto_tick) else $error("auto-refresh missed");

	property p_row_width;
		wr_control ##1 !wr_control |=> ROW_BITS_O >= 4'hB && ROW_BITS_O <= 4'hD;
	endproperty
	a_row_width: assert property (p_row_width) else $error("row width out of range");

	property p_col_width;
		wr_control ##1 !wr_control |=> COL_BITS_O >= 4'h8 && COL_BITS_O <= 4'hA;
	endproperty
	a_col_width: assert property (p_col_width) else $error("column width out of range");
endmodule

// ### test/sdt_sdram_model.sv
// command side of the external sdram, measures spacing seen on the ok levels
`timescale 1ns/1ps
module sdt_sdram_model (
	input  wire logic clk_i,
	input  wire logic clr_i,
	input  wire logic wr_go_i,
	input  wire logic ref_go_i,
	input  wire logic pre_ok_i,
	input  wire logic act_ok_i,
	output logic      write_cmd_o,
	output logic      refresh_cmd_o,
	output int        pre_low_o,
	output int        act_low_o
);
	initial begin
		write_cmd_o = 1'b0;
		refresh_cmd_o = 1'b0;
		pre_low_o = 0;
		act_low_o = 0;
	end
	// ==========================================================
	// one-cycle command pulses and low-cycle counters
	always @(posedge clk_i) begin
		write_cmd_o <= wr_go_i;
		refresh_cmd_o <= ref_go_i;
		if (clr_i || wr_go_i)
			pre_low_o <= 0;
		else if (!pre_ok_i)
			pre_low_o <= pre_low_o + 1;
		if (clr_i || ref_go_i)
			act_low_o <= 0;
		else if (!act_ok_i)
			act_low_o <= act_low_o + 1;
	end
endmodule

// ### test/tb_top.sv
// self-checking bench for the sdram timing and control registers
`timescale 1ns/1ps
module tb_top;
	logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q, v, tim, ctl;
	logic        pready, pslverr, e, wcmd, rcmd, tick = 1'b0, pre_ok, act_ok;
	logic        ren, selfr, areq, slow, clr = 1'b0, wgo = 1'b0, rgo = 1'b0;
	logic [3:0]  row_bits, col_bits;
	int          n_mismatch = 0, compares = 0, pre_low, act_low, n_auto;
	int          twr_tab[3] = '{0, 1, 2};
	int          trc_tab[4] = '{3, 4, 6, 9};

	sdt_timing_config #(.ADDR_W(12)) u_dut (.SYS_CLK_I(clk), .SYS_RST_I(rst),
		.PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.WRITE_CMD_I(wcmd), .REFRESH_CMD_I(rcmd), .REFRESH_TICK_I(tick),
		.PRECHARGE_OK_O(pre_ok), .ACTIVATE_OK_O(act_ok), .REFRESH_ENABLE_O(ren),
		.SELF_REFRESH_O(selfr), .AUTO_REFRESH_REQ_O(areq), .LOW_FREQ_MODE_O(slow),
		.ROW_BITS_O(row_bits), .COL_BITS_O(col_bits));
	sdt_sdram_model u_mem (.clk_i(clk), .clr_i(clr), .wr_go_i(wgo), .ref_go_i(rgo),
		.pre_ok_i(pre_ok), .act_ok_i(act_ok), .write_cmd_o(wcmd), .refresh_cmd_o(rcmd),
		.pre_low_o(pre_low), .act_low_o(act_low));

	initial begin
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		if (clr)
			n_auto <= 0;
		else if (areq)
			n_auto <= n_auto + 1;
	end
	// ==========================================================
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16)
			chk(32'h0000_0000, 32'h0000_0001);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		if (a == 12'h000) begin
			if (d[4:3] != 2'h3)
				tim[4:3] = d[4:3];
			tim[1:0] = d[1:0];
		end else if (a == 12'h004) begin
			if (d[20:19] != 2'h3)
				ctl[20:19] = d[20:19];
			if (d[17:16] != 2'h3)
				ctl[17:16] = d[17:16];
			ctl[12:10] = d[12:10];
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(q, exp);
	endtask
	task automatic go(input bit r);
		@(posedge clk);
		clr <= 1'b1;
		wgo <= !r;
		rgo <= r;
		tick <= r;
		@(posedge clk);
		clr <= 1'b0;
		wgo <= 1'b0;
		rgo <= 1'b0;
		tick <= 1'b0;
		repeat (14) @(posedge clk);
	endtask
	task automatic print_verdict;
		$display("mismatches %0d, compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ==========================================================
	// tests
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		print_verdict();
	end
	initial begin
		void'($urandom(32'h21d5d625));
		tim = 32'h0000_0000;
		ctl = 32'h0000_0000;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd(12'h000, 32'h0000_0000);
		rd(12'h004, 32'h0000_0000);
		rd(12'h008, 32'h0000_0003);
		chk({row_bits, col_bits}, {4'hB, 4'h8});
		// control set once after each reset, before any area access
		for (int i = 0; i < 16; i++) begin
			rst <= 1'b1;
			repeat (2) @(posedge clk);
			rst <= 1'b0;
			tim = 32'h0000_0000;
			ctl = 32'h0000_0000;
			v = ($urandom() & 32'h0000_1C00) | {11'h0, i[3:2], 1'b0, i[1:0], 16'h0};
			wr(12'h004, v);
			rd(12'h004, ctl);
			chk({row_bits, col_bits}, {4'hB + ctl[20:19], 4'h8 + ctl[17:16]});
			chk({slow, ren, selfr}, {ctl[12], ctl[11], ctl[11] & ctl[10]});
		end
		wr(12'h004, ctl & 32'hFFFF_F3FF);
		for (int i = 0; i < 16; i++) begin
			v = {27'h0, i[3:2], 1'b0, i[1:0]};
			wr(12'h000, v);
			rd(12'h000, tim);
			go(1'b0);
			chk(pre_low, twr_tab[tim[4:3]]);
			go(1'b1);
			chk(act_low, trc_tab[tim[1:0]]);
		end
		for (int m = 0; m < 4; m++) begin
			wr(12'h004, (ctl & 32'hFFFF_F3FF) | (m << 10));
			go(1'b1);
			chk(n_auto, (m == 2) ? 1 : 0);
			chk({ren, selfr}, {m[1], m == 3});
		end
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		wr(12'h004, (ctl & 32'hFFFF_F3FF) | 32'h0000_0800);
		repeat (14) @(posedge clk);
		chk(act_low, trc_tab[tim[1:0]]);
		apb(1'b0, 12'h00C, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		chk({31'h0, e}, 32'h0000_0001);
		apb(1'b1, 12'h010, 32'hFFFF_FFFF);
		chk(e, 1'b1);
		wr(12'h008, 32'hFFFF_FFFF);
		rd(12'h008, 32'h0000_0003);
		rd(12'h000, tim);
		print_verdict();
	end
endmodule
